// >>> rtl/tsr_top.sv
`timescale 1ns/1ps
`include "tsr_map.svh"
// How it works
// - writing 09h to self test control arms the self test
// - after arming, a zero byte plus CRC command runs the self test
// - self test leaves exactly 64 pattern bytes, pattern per version
// - five-bit group select picks internal signals for D1 to D6
// - group 0Dh: stable clock D6, clock/8 D5, raw clock D2
// - group 07h: receiver data, collision, valid, over, clear
// - aux codes 0 to 6: off, DAC reg, correlator, level, ADC
// - aux codes A to F: high, low, tx, rx, subcarrier, test line
// - upper nibble drives aux pin one, lower nibble aux pin two
// - DAC register selection follows its own 00h to 3Fh level
// - at 106 kBd rx busy covers data, parity, CRC, not start
// - at 106 kBd tx busy covers start, data, parity, CRC
// - faster rates: busy only during data bits and CRC
// - three-bit line pick chooses the selected test line
// - PRBS9 or PRBS15 starts sending on the transmit command
// - framing bits are inserted by the framer per current mode
module tsr_top
    import tsr_pkg::*;
#(
    parameter int PATTERN_VERSION = 2
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire tsr_rx_t rx_sig,
    input wire tsr_osc_t osc_sig,
    input wire tsr_ana_t ana_sig,
    output logic [6:1] test_pin,
    output logic test_pin_oe,
    output logic [5:0] aux_pin_one,
    output logic aux_pin_one_oe,
    output logic [5:0] aux_pin_two,
    output logic aux_pin_two_oe,
    output logic prbs_bit,
    output logic prbs_valid
);
    initial begin
        if (PATTERN_VERSION != 1 && PATTERN_VERSION != 2)
            $error("tsr_top: PATTERN_VERSION must be 1 or 2");
    end

    // ********************************************************
    // pin input synchronisers
    // ********************************************************
    tsr_rx_t rx_s1, rx_s2;
    tsr_osc_t osc_s1, osc_s2;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_s1 <= '0;
            rx_s2 <= '0;
            osc_s1 <= '0;
            osc_s2 <= '0;
        end else begin
            rx_s1 <= rx_sig;
            rx_s2 <= rx_s1;
            osc_s1 <= osc_sig;
            osc_s2 <= osc_s1;
        end
    end

    // ********************************************************
    // registers
    // ********************************************************
    logic [7:0] self_test_control_reg, next_self_test_control_reg;
    logic [7:0] first_test_select_reg, next_first_test_select_reg;
    logic [7:0] second_test_select_reg, next_second_test_select_reg;
    logic [7:0] aux_pin_select_reg, next_aux_pin_select_reg;
    logic [5:0] dac_level_one_reg, next_dac_level_one_reg;
    logic [5:0] dac_level_two_reg, next_dac_level_two_reg;
    logic [31:0] next_prdata;
    logic wr, rd, fifo_push, fifo_pop, cmd_crc, cmd_setup, cmd_tx;
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign fifo_push = wr && paddr == `TSR_ADDR_FIFO;
    assign fifo_pop = rd && paddr == `TSR_ADDR_FIFO;
    assign cmd_crc = wr && paddr == `TSR_ADDR_CMD
        && pwdata[3:0] == `TSR_CMD_CRC;
    assign cmd_setup = wr && paddr == `TSR_ADDR_CMD
        && pwdata[3:0] == `TSR_CMD_BUF_SETUP;
    assign cmd_tx = wr && paddr == `TSR_ADDR_CMD
        && pwdata[3:0] == `TSR_CMD_TRANSMIT;

    // ********************************************************
    // self test fifo and pattern
    // ********************************************************
    logic [7:0] fifo_mem [`TSR_FIFO_DEPTH];
    logic [6:0] fifo_cnt, next_fifo_cnt;
    logic [5:0] rd_ptr, next_rd_ptr, wr_ptr, next_wr_ptr;
    logic [5:0] st_idx, next_st_idx;
    tsr_st_t st, next_st;
    logic [7:0] pat_byte;
    logic [511:0] pat_v1, pat_v2;
    assign pat_v1 = {
        64'h00c637d532b7575c, 64'hc2d87c4dd970c773,
        64'h10e6d2aa5ea13e5a, 64'h14af3061c970db2e,
        64'h642272b5bd65f4ec, 64'h22bcd37235cdaa41,
        64'h1fa7f35314de7e02, 64'hd90fb55e251d2979};
    assign pat_v2 = {
        64'h00eb66ba57bf2395, 64'hd0e30d3d27895cde,
        64'h9d3ba700215b8982, 64'h513aeb020ca50049,
        64'h7c844db3ccd21b81, 64'h5d4876d5716121a9,
        64'h86968338cf9d5b6d, 64'hdc15ba3e7d953b2f};
    always_comb begin
        pat_byte = (PATTERN_VERSION == 1)
            ? pat_v1[9'(511 - 8 * st_idx) -: 8]
            : pat_v2[9'(511 - 8 * st_idx) -: 8];
    end

    always_comb begin
        next_st = st;
        next_st_idx = st_idx;
        next_fifo_cnt = fifo_cnt;
        next_rd_ptr = rd_ptr;
        next_wr_ptr = wr_ptr;
        case (st)
            TSR_IDLE: begin
                if (cmd_setup) begin
                    next_rd_ptr = 6'h00;
                    next_wr_ptr = 6'h00;
                    next_fifo_cnt = 7'h00;
                end else if (cmd_crc && self_test_control_reg
                        == `TSR_ARM_CODE) begin
                    next_st = TSR_RUN;
                    next_st_idx = 6'h00;
                    next_rd_ptr = 6'h00;
                    next_wr_ptr = 6'h00;
                    next_fifo_cnt = 7'h00;
                end else begin
                    if (fifo_push && fifo_cnt != 7'h40) begin
                        next_wr_ptr = wr_ptr + 6'h01;
                        next_fifo_cnt = fifo_cnt + 7'h01;
                    end
                    if (fifo_pop && fifo_cnt != 7'h00) begin
                        next_rd_ptr = rd_ptr + 6'h01;
                        next_fifo_cnt = next_fifo_cnt - 7'h01;
                    end
                end
            end
            TSR_RUN: begin
                // fill all 64 entries, one per cycle
                next_wr_ptr = wr_ptr + 6'h01;
                next_fifo_cnt = fifo_cnt + 7'h01;
                next_st_idx = st_idx + 6'h01;
                if (st_idx == 6'h3f)
                    next_st = TSR_DONE;
            end
            TSR_DONE: next_st = TSR_IDLE;
            default: next_st = TSR_IDLE;
        endcase
    end

    always_ff @(posedge pclk) begin
        if (st == TSR_RUN)
            fifo_mem[wr_ptr] <= pat_byte;
        else if (st == TSR_IDLE && fifo_push && fifo_cnt != 7'h40)
            fifo_mem[wr_ptr] <= pwdata[7:0];
    end

    // ********************************************************
    // register writes
    // ********************************************************
    always_comb begin
        next_self_test_control_reg = self_test_control_reg;
        next_first_test_select_reg = first_test_select_reg;
        next_second_test_select_reg = second_test_select_reg;
        next_aux_pin_select_reg = aux_pin_select_reg;
        next_dac_level_one_reg = dac_level_one_reg;
        next_dac_level_two_reg = dac_level_two_reg;
        if (wr) begin
            case (paddr)
                `TSR_ADDR_SELF_TEST:
                    next_self_test_control_reg = pwdata[7:0];
                `TSR_ADDR_SEL_ONE:
                    next_first_test_select_reg = pwdata[7:0];
                `TSR_ADDR_SEL_TWO:
                    next_second_test_select_reg = pwdata[7:0];
                `TSR_ADDR_AUX: next_aux_pin_select_reg = pwdata[7:0];
                `TSR_ADDR_DAC_ONE: next_dac_level_one_reg = pwdata[5:0];
                `TSR_ADDR_DAC_TWO: next_dac_level_two_reg = pwdata[5:0];
                default: ;
            endcase
        end
        next_prdata = 32'h0000_0000;
        if (psel && !penable && !pwrite) begin
            case (paddr)
                `TSR_ADDR_SELF_TEST:
                    next_prdata = {24'h0, self_test_control_reg};
                `TSR_ADDR_SEL_ONE:
                    next_prdata = {24'h0, first_test_select_reg};
                `TSR_ADDR_SEL_TWO:
                    next_prdata = {24'h0, second_test_select_reg};
                `TSR_ADDR_AUX: next_prdata = {24'h0, aux_pin_select_reg};
                `TSR_ADDR_DAC_ONE:
                    next_prdata = {26'h0, dac_level_one_reg};
                `TSR_ADDR_DAC_TWO:
                    next_prdata = {26'h0, dac_level_two_reg};
                `TSR_ADDR_FIFO: next_prdata = {24'h0, fifo_mem[rd_ptr]};
                `TSR_ADDR_STATUS:
                    next_prdata = {23'h0, st != TSR_IDLE, 1'b0, fifo_cnt};
                default: next_prdata = 32'h0000_0000;
            endcase
        end
    end

    // ********************************************************
    // test bus and oscillator divider
    // ********************************************************
    logic [1:0] div_cnt, next_div_cnt;
    logic div_clk, next_div_clk, raw_q;
    logic [6:1] next_test_pin;
    logic next_test_pin_oe, next_sel_line;
    logic selected_test_line;
    logic [4:0] test_bus_group_select;
    logic [2:0] test_bus_line_pick;
    assign test_bus_group_select = second_test_select_reg[4:0];
    assign test_bus_line_pick = first_test_select_reg[2:0];
    always_comb begin
        // count rising raw edges; four per half period gives divide by 8
        next_div_cnt = div_cnt;
        next_div_clk = div_clk;
        if (osc_s2.raw && !raw_q) begin
            next_div_cnt = div_cnt + 2'h1;
            if (div_cnt == `TSR_OSC_DIV_HALF)
                next_div_clk = !div_clk;
        end
        next_test_pin = 6'h00;
        next_test_pin_oe = 1'b1;
        case (test_bus_group_select)
            `TSR_GRP_RX:
                next_test_pin = {rx_s2.data, rx_s2.coll, rx_s2.valid,
                    rx_s2.over, rx_s2.clear, 1'b0};
            `TSR_GRP_OSC:
                next_test_pin = {osc_s2.stable, div_clk, 2'b00,
                    osc_s2.raw, 1'b0};
            default: next_test_pin_oe = 1'b0;
        endcase
        next_sel_line = 1'b0;
        if (test_bus_line_pick != 3'h0)
            next_sel_line = next_test_pin[test_bus_line_pick];
    end

    // ********************************************************
    // prbs generator
    // ********************************************************
    logic [14:0] lfsr, next_lfsr;
    logic next_prbs_bit, next_prbs_valid, fb;
    logic [1:0] prbs_mode;
    assign prbs_mode = second_test_select_reg[6:5];
    always_comb begin
        // framing is added downstream by the mode-aware framer
        fb = (prbs_mode == `TSR_PRBS9) ? (lfsr[8] ^ lfsr[4])
            : (lfsr[14] ^ lfsr[13]);
        next_lfsr = lfsr;
        next_prbs_valid = prbs_valid;
        next_prbs_bit = 1'b0;
        if (prbs_mode != `TSR_PRBS9 && prbs_mode != `TSR_PRBS15) begin
            next_prbs_valid = 1'b0;
            next_lfsr = 15'h7fff;
        end else if (cmd_tx) begin
            next_prbs_valid = 1'b1;
            next_prbs_bit = 1'b1;
            next_lfsr = 15'h7fff;
        end else if (prbs_valid) begin
            next_lfsr = {lfsr[13:0], fb};
            next_prbs_bit = fb;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            self_test_control_reg <= 8'h00;
            first_test_select_reg <= 8'h00;
            second_test_select_reg <= 8'h00;
            aux_pin_select_reg <= 8'h00;
            dac_level_one_reg <= 6'h00;
            dac_level_two_reg <= 6'h00;
            prdata <= 32'h0000_0000;
            st <= TSR_IDLE;
            st_idx <= 6'h00;
            fifo_cnt <= 7'h00;
            rd_ptr <= 6'h00;
            wr_ptr <= 6'h00;
            div_cnt <= 2'h0;
            div_clk <= 1'b0;
            raw_q <= 1'b0;
            test_pin <= 6'h00;
            test_pin_oe <= 1'b0;
            selected_test_line <= 1'b0;
            lfsr <= 15'h7fff;
            prbs_bit <= 1'b0;
            prbs_valid <= 1'b0;
        end else begin
            self_test_control_reg <= next_self_test_control_reg;
            first_test_select_reg <= next_first_test_select_reg;
            second_test_select_reg <= next_second_test_select_reg;
            aux_pin_select_reg <= next_aux_pin_select_reg;
            dac_level_one_reg <= next_dac_level_one_reg;
            dac_level_two_reg <= next_dac_level_two_reg;
            prdata <= next_prdata;
            st <= next_st;
            st_idx <= next_st_idx;
            fifo_cnt <= next_fifo_cnt;
            rd_ptr <= next_rd_ptr;
            wr_ptr <= next_wr_ptr;
            div_cnt <= next_div_cnt;
            div_clk <= next_div_clk;
            raw_q <= osc_s2.raw;
            test_pin <= next_test_pin;
            test_pin_oe <= next_test_pin_oe;
            selected_test_line <= next_sel_line;
            lfsr <= next_lfsr;
            prbs_bit <= next_prbs_bit;
            prbs_valid <= next_prbs_valid;
        end
    end

    // ********************************************************
    // auxiliary pins
    // ********************************************************
    // busy flags arrive already shaped per rate by the framer
    tsr_aux_mux u_aux_one (
        .source(aux_pin_select_reg[7:4]),
        .dac_level(dac_level_one_reg),
        .ana(ana_sig),
        .test_line(selected_test_line),
        .level(aux_pin_one),
        .oe(aux_pin_one_oe)
    );
    tsr_aux_mux u_aux_two (
        .source(aux_pin_select_reg[3:0]),
        .dac_level(dac_level_two_reg),
        .ana(ana_sig),
        .test_line(selected_test_line),
        .level(aux_pin_two),
        .oe(aux_pin_two_oe)
    );
endmodule

// >>> rtl/tsr_map.svh
`ifndef TSR_MAP_SVH
`define TSR_MAP_SVH
// register byte addresses
`define TSR_ADDR_SELF_TEST 12'h000
`define TSR_ADDR_SEL_ONE 12'h004
`define TSR_ADDR_SEL_TWO 12'h008
`define TSR_ADDR_AUX 12'h00c
`define TSR_ADDR_DAC_ONE 12'h010
`define TSR_ADDR_DAC_TWO 12'h014
`define TSR_ADDR_CMD 12'h018
`define TSR_ADDR_FIFO 12'h01c
`define TSR_ADDR_STATUS 12'h020
`define TSR_ARM_CODE 8'h09
`define TSR_CMD_BUF_SETUP 4'h1
`define TSR_CMD_CRC 4'h3
`define TSR_CMD_TRANSMIT 4'h4
`define TSR_GRP_RX 5'h07
`define TSR_GRP_OSC 5'h0d
`define TSR_PRBS_OFF 2'h0
`define TSR_PRBS9 2'h1
`define TSR_PRBS15 2'h2
`define TSR_FIFO_DEPTH 64
`define TSR_DAC_MAX 6'h3f
`define TSR_OSC_DIV_HALF 2'h3
`endif

// >>> rtl/tsr_pkg.sv
package tsr_pkg;
    typedef struct packed {
        logic data;
        logic coll;
        logic valid;
        logic over;
        logic clear;
    } tsr_rx_t;
    typedef struct packed {
        logic stable;
        logic raw;
    } tsr_osc_t;
    typedef struct packed {
        logic [5:0] corr;
        logic [5:0] minimum;
        logic [5:0] adc_i;
        logic [5:0] adc_q;
        logic tx_busy;
        logic rx_busy;
        logic subcarrier;
    } tsr_ana_t;
    typedef enum logic [1:0] {
        TSR_IDLE, TSR_RUN, TSR_DONE
    } tsr_st_t;
endpackage

// >>> rtl/tsr_aux_mux.sv
`timescale 1ns/1ps
`include "tsr_map.svh"
// ************************************************************
// one auxiliary pin selector
// ************************************************************
module tsr_aux_mux
    import tsr_pkg::*;
(
    input wire logic [3:0] source,
    input wire logic [5:0] dac_level,
    input wire tsr_ana_t ana,
    input wire logic test_line,
    output logic [5:0] level,
    output logic oe
);
    always_comb begin
        level = 6'h00;
        oe = 1'b1;
        case (source)
            4'h0: oe = 1'b0;
            4'h1: level = dac_level;
            4'h2: level = ana.corr;
            4'h4: level = ana.minimum;
            4'h5: level = ana.adc_i;
            4'h6: level = ana.adc_q;
            4'ha: level = `TSR_DAC_MAX;
            4'hb: level = 6'h00;
            4'hc: level = {6{ana.tx_busy}};
            4'hd: level = {6{ana.rx_busy}};
            4'he: level = {6{ana.subcarrier}};
            4'hf: level = {6{test_line}};
            // reserved codes stay undriven
            default: oe = 1'b0;
        endcase
    end
endmodule

// >>> dv/tsr_front_model.sv
`timescale 1ns/1ps
// ************************************************************
// receiver, oscillator and analog front end stand-in
// ************************************************************
module tsr_front_model
    import tsr_pkg::*;
(
    input wire logic pclk,
    input wire logic [7:0] scene,
    output tsr_rx_t rx_sig,
    output tsr_osc_t osc_sig,
    output tsr_ana_t ana_sig
);
    // fields are plain functions of scene
    always @(posedge pclk) begin
        rx_sig <= tsr_rx_t'(scene[4:0]);
        osc_sig <= tsr_osc_t'(scene[6:5]);
        ana_sig <= {scene[5:0], ~scene[5:0], scene[5:0] ^ 6'h2a,
            6'h3f - scene[5:0], scene[2:0]};
    end
endmodule

// >>> dv/tsr_top_assertions.sv
`timescale 1ns/1ps
`include "tsr_map.svh"
module tsr_top_assertions
    import tsr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire tsr_rx_t rx_sig,
    input wire tsr_osc_t osc_sig,
    input wire tsr_ana_t ana_sig,
    input wire logic [6:1] test_pin,
    input wire logic test_pin_oe,
    input wire logic [5:0] aux_pin_one,
    input wire logic aux_pin_one_oe,
    input wire logic [5:0] aux_pin_two,
    input wire logic aux_pin_two_oe,
    input wire logic prbs_bit,
    input wire logic prbs_valid
);
    // ************************************************************
    // shadow registers rebuilt from completed writes
    // ************************************************************
    logic wr;
    logic [7:0] aux;
    logic [5:0] dac1;
    logic [4:0] grp;
    logic [1:0] mode;
    logic tx_seen;
    logic [2:0] hold;
    logic [3:0] run;
    assign wr = psel && penable && pwrite && pready;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux <= 8'h00;
            dac1 <= 6'h00;
            grp <= 5'h00;
            mode <= 2'h0;
            tx_seen <= 1'b0;
            hold <= 3'h0;
            run <= 4'h0;
        end else begin
            if (wr && paddr == `TSR_ADDR_AUX) aux <= pwdata[7:0];
            if (wr && paddr == `TSR_ADDR_DAC_ONE) dac1 <= pwdata[5:0];
            if (wr && paddr == `TSR_ADDR_CMD && pwdata[3:0] == 4'h4)
                tx_seen <= 1'b1;
            // group changes restart the settle count of the bus pipeline
            if (wr && paddr == `TSR_ADDR_SEL_TWO) begin
                grp <= pwdata[4:0];
                mode <= pwdata[6:5];
                hold <= 3'h0;
            end else if (hold != 3'h4) hold <= hold + 3'h1;
            run <= prbs_valid ? run + {3'h0, run != 4'hf} : 4'h0;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_ZERO_WAIT: assert property (psel && penable |-> pready && !pslverr)
        else $error("access not completed without wait or error");
    AST_AUX_OFF: assert property (aux[7:4] == 4'h0 |-> !aux_pin_one_oe)
        else $error("aux one driven while three-stated");
    AST_AUX_DAC: assert property (aux[7:4] == 4'h1 |-> aux_pin_one_oe && aux_pin_one == dac1)
        else $error("aux one does not follow its dac level");
    AST_AUX_CORR: assert property (aux[7:4] == 4'h2 |-> aux_pin_one == ana_sig.corr)
        else $error("aux one does not carry correlator");
    AST_AUX_TWO_MIN: assert property (aux[3:0] == 4'h4 |-> aux_pin_two_oe && aux_pin_two == ana_sig.minimum)
        else $error("aux two does not carry minimum level");
    AST_AUX_CONST: assert property (aux[7:4] inside {4'ha, 4'hb} |-> aux_pin_one == {6{~aux[4]}})
        else $error("aux one constant level wrong");
    AST_AUX_RESERVED: assert property (aux[7:4] inside {4'h3, 4'h7, 4'h8, 4'h9} |-> !aux_pin_one_oe)
        else $error("aux one driven on reserved code");
    AST_BUS_OE: assert property (hold == 3'h4 |-> test_pin_oe == (grp inside {`TSR_GRP_RX, `TSR_GRP_OSC}))
        else $error("test pin enable disagrees with group");
    AST_RX_DATA: assert property (hold == 3'h4 && grp == `TSR_GRP_RX |-> test_pin[6] == $past(rx_sig.data, 3))
        else $error("received data not on pin six");
    AST_PRBS9: assert property (mode == 2'h1 && prbs_valid && run >= 4'h9 |-> prbs_bit == ($past(prbs_bit, 9) ^ $past(prbs_bit, 5)))
        else $error("short sequence recurrence broken");
    AST_PRBS15: assert property (mode == 2'h2 && prbs_valid && run == 4'hf |-> prbs_bit == ($past(prbs_bit, 15) ^ $past(prbs_bit, 14)))
        else $error("long sequence recurrence broken");
    AST_PRBS_START: assert property ($rose(prbs_valid) |-> tx_seen)
        else $error("sequence began without transmit command");
    cover property (aux == 8'h11);
    cover property (hold == 3'h4 && grp == `TSR_GRP_OSC && test_pin_oe);
    cover property (prbs_valid && mode == 2'h2);
endmodule

// >>> dv/tb_top.sv
`timescale 1ns/1ps
`include "tsr_map.svh"
module tb_top
    import tsr_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    tsr_rx_t rx_sig;
    tsr_osc_t osc_sig;
    tsr_ana_t ana_sig;
    logic [6:1] test_pin;
    logic [5:0] aux_pin_one, aux_pin_two;
    logic test_pin_oe, aux_pin_one_oe, aux_pin_two_oe, prbs_bit, prbs_valid;
    logic [7:0] scene;
    logic [39:0] bits;
    logic [511:0] pat;
    int n_mismatch, tests_run;
    tsr_top #(.PATTERN_VERSION(2)) u_tsr_top (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_sig(rx_sig), .osc_sig(osc_sig), .ana_sig(ana_sig),
        .test_pin(test_pin), .test_pin_oe(test_pin_oe),
        .aux_pin_one(aux_pin_one), .aux_pin_one_oe(aux_pin_one_oe),
        .aux_pin_two(aux_pin_two), .aux_pin_two_oe(aux_pin_two_oe),
        .prbs_bit(prbs_bit), .prbs_valid(prbs_valid));
    tsr_front_model u_tsr_front_model (.pclk(pclk), .scene(scene),
        .rx_sig(rx_sig), .osc_sig(osc_sig), .ana_sig(ana_sig));
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // ************************************************************
    // bus and checking tasks
    // ************************************************************
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic tmo(input int n, input int lim);
        if (n >= lim) begin
            n_mismatch++;
            print_verdict();
        end
    endtask
    task automatic chk(input string nm, input logic [31:0] seen,
            input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // read data is taken at the last edge
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            q = prdata;
            n++;
        end while (pready !== 1'b1 && n < 20);
        tmo(n, 20);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [6:0] aux_exp(input logic [3:0] c,
            input logic [5:0] dac, input logic [7:0] s);
        case (c)
            4'h1: return {1'b1, dac};
            4'h2: return {1'b1, s[5:0]};
            4'h4: return {1'b1, ~s[5:0]};
            4'h5: return {1'b1, s[5:0] ^ 6'h2a};
            4'h6: return {1'b1, 6'h3f - s[5:0]};
            4'ha: return 7'h7f;
            4'hb: return 7'h40;
            4'hc: return {1'b1, {6{s[2]}}};
            4'hd: return {1'b1, {6{s[1]}}};
            4'he: return {1'b1, {6{s[0]}}};
            4'hf: return {1'b1, {6{s[4]}}};
            default: return 7'h00;
        endcase
    endfunction
    task automatic prbs(input logic [31:0] m, input int ta, input int tb);
        int n = 0;
        apb(1'b1, `TSR_ADDR_SEL_TWO, m);
        chk("prbs idle", 32'(prbs_valid), 32'h0);
        apb(1'b1, `TSR_ADDR_CMD, 32'(`TSR_CMD_TRANSMIT));
        while (prbs_valid !== 1'b1 && n < 50) begin
            @(posedge pclk);
            #1 n++;
        end
        tmo(n, 50);
        for (int i = 0; i < 40; i++) begin
            bits[i] = prbs_bit;
            @(posedge pclk);
            #1;
        end
        for (int i = 15; i < 40; i++)
            chk("prbs bit", 32'(bits[i]), 32'(bits[i-ta] ^ bits[i-tb]));
        $display("test prbs mode %0h done", m);
    endtask
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        int n;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        scene = 8'h00;
        presetn = 1'b0;
        n_mismatch = 0;
        tests_run = 0;
        pat = {128'h00eb66ba57bf2395d0e30d3d27895cde,
            128'h9d3ba700215b8982513aeb020ca50049,
            128'h7c844db3ccd21b815d4876d5716121a9,
            128'h86968338cf9d5b6ddc15ba3e7d953b2f};
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 25; i++) apb(1'b1, `TSR_ADDR_FIFO, 32'h0);
        apb(1'b1, `TSR_ADDR_CMD, 32'(`TSR_CMD_BUF_SETUP));
        apb(1'b1, `TSR_ADDR_SELF_TEST, 32'(`TSR_ARM_CODE));
        apb(1'b1, `TSR_ADDR_FIFO, 32'h0);
        apb(1'b1, `TSR_ADDR_CMD, 32'(`TSR_CMD_CRC));
        n = 0;
        do begin
            apb(1'b0, `TSR_ADDR_STATUS, 32'h0);
            n++;
        end while (q[8] !== 1'b0 && n < 200);
        tmo(n, 200);
        chk("fifo count", 32'(q[6:0]), 32'd64);
        for (int i = 0; i < 64; i++) begin
            apb(1'b0, `TSR_ADDR_FIFO, 32'h0);
            chk("self test byte", q, 32'(pat[511-8*i -: 8]));
        end
        apb(1'b0, 12'h030, 32'h0);
        chk("unmapped read", q, 32'h0);
        $display("test self test done");
        scene <= 8'h15;
        apb(1'b1, `TSR_ADDR_SEL_TWO, 32'(`TSR_GRP_RX));
        repeat (5) @(posedge pclk);
        #1 chk("bus rx", 32'({test_pin_oe, test_pin}), 32'h6a);
        scene <= 8'h40;
        apb(1'b1, `TSR_ADDR_SEL_TWO, 32'(`TSR_GRP_OSC));
        repeat (5) @(posedge pclk);
        #1 chk("bus osc", 32'({test_pin_oe, test_pin[6], test_pin[2]}), 32'h6);
        apb(1'b1, `TSR_ADDR_SEL_TWO, 32'h1f);
        repeat (5) @(posedge pclk);
        #1 chk("bus reserved", 32'(test_pin_oe), 32'h0);
        $display("test bus done");
        apb(1'b1, `TSR_ADDR_DAC_ONE, 32'(`TSR_DAC_MAX));
        apb(1'b1, `TSR_ADDR_DAC_TWO, 32'h0);
        apb(1'b1, `TSR_ADDR_SEL_ONE, 32'h6);
        apb(1'b1, `TSR_ADDR_SEL_TWO, 32'(`TSR_GRP_RX));
        for (int k = 0; k < 2; k++) begin
            scene <= k ? 8'h28 : 8'h57;
            for (int c = 0; c < 16; c++) begin
                apb(1'b1, `TSR_ADDR_AUX, 32'({c[3:0], c[3:0] ^ 4'h5}));
                repeat (5) @(posedge pclk);
                #1 chk("aux one", 32'({aux_pin_one_oe, aux_pin_one_oe ? aux_pin_one : 6'h0}),
                    32'(aux_exp(c[3:0], 6'h3f, k ? 8'h28 : 8'h57)));
                chk("aux two", 32'({aux_pin_two_oe, aux_pin_two_oe ? aux_pin_two : 6'h0}),
                    32'(aux_exp(c[3:0] ^ 4'h5, 6'h0, k ? 8'h28 : 8'h57)));
            end
        end
        $display("test aux done");
        prbs(32'h20, 9, 5);
        // a reset in mid-run must stop the sequence and allow a clean restart
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        prbs(32'h40, 15, 14);
        print_verdict();
    end
endmodule
bind tsr_top tsr_top_assertions u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_sig(rx_sig), .osc_sig(osc_sig), .ana_sig(ana_sig),
    .test_pin(test_pin), .test_pin_oe(test_pin_oe),
    .aux_pin_one(aux_pin_one), .aux_pin_one_oe(aux_pin_one_oe),
    .aux_pin_two(aux_pin_two), .aux_pin_two_oe(aux_pin_two_oe),
    .prbs_bit(prbs_bit), .prbs_valid(prbs_valid));
